// ==== rtl/scs_sequencer.v ====
// terminal-side supply class sequencer: activation, retries, class switch, power grant
// assumes the reset engine and answer parser report through one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
`include "scs_defines.vh"
module scs_sequencer (
   input  wire       clock,
   input  wire       arst_n,
   input  wire [4:0] term_classes,
   input  wire       start,
   input  wire       act_done,
   input  wire       atr_none,
   input  wire       atr_ok,
   input  wire       atr_corrupt,
   input  wire [4:0] atr_classes,
   input  wire       atr_classes_present,
   input  wire       cap_cmd_higher,
   input  wire       app_access_ok,
   input  wire       app_cmd_done,
   input  wire       app_no_access_cond,
   input  wire       app_power_valid,
   input  wire       app_power_over,
   input  wire       usb_activate,
   input  wire       power_down,
   output reg        vcc_on,
   output reg  [4:0] vcc_class,
   output reg        rst_assert_n,
   output reg        activate_req,
   output reg        apdu_allowed,
   output reg        rejected,
   output reg        deselect_req,
   output reg  [1:0] current_allow,
   output reg        class_bad_adv
);
   localparam [2:0] ST_IDLE  = 3'h0;
   localparam [2:0] ST_ACT   = 3'h1;
   localparam [2:0] ST_WAIT  = 3'h2;
   localparam [2:0] ST_DEACT = 3'h3;
   localparam [2:0] ST_READY = 3'h4;
   localparam [2:0] ST_REJ   = 3'h5;
   localparam integer DEACT_CYC_INT = `SCS_DEACT_CYC;
   localparam [8:0]   DEACT_CYC     = DEACT_CYC_INT[8:0];

   reg  [2:0] state_reg;
   reg  [1:0] corrupt_cnt_reg;
   reg        first_class_reg;
   reg        corrupt_retry_reg;
   reg  [8:0] timer_reg;
   reg  [4:0] next_class_reg;
   reg        cap_granted_reg;
   reg        app_sel_reg;
   wire       cur_ok;
   wire       adjacent_ok;
   wire [4:0] pick_class;
   wire [4:0] lowest_class;
   wire [4:0] next_higher;

   scs_class_eval scs_class_eval_inst (
      .adv_classes (atr_classes),
      .term_classes(term_classes),
      .cur_class   (vcc_class),
      .cur_ok      (cur_ok),
      .adjacent_ok (adjacent_ok),
      .pick_class  (pick_class)
   );

   // highest set bit is the lowest voltage, class A in bit 0 being the highest
   assign lowest_class = term_classes[4] ? 5'h10 :
                         term_classes[3] ? 5'h08 :
                         term_classes[2] ? 5'h04 :
                         term_classes[1] ? 5'h02 :
                         {4'h0, term_classes[0]};
   // higher voltage means lower bit index here: next class is the next bit down
   assign next_higher  = {1'b0, vcc_class[4:1]} & term_classes;

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_reg         <= ST_IDLE;
         corrupt_cnt_reg   <= 2'h0;
         first_class_reg   <= 1'b0;
         corrupt_retry_reg <= 1'b0;
         timer_reg         <= 9'h000;
         next_class_reg    <= 5'h00;
         vcc_on            <= 1'b0;
         vcc_class         <= 5'h00;
         rst_assert_n      <= 1'b0;
         activate_req      <= 1'b0;
         apdu_allowed      <= 1'b0;
         rejected          <= 1'b0;
         class_bad_adv     <= 1'b0;
      end else begin
         activate_req <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (start && (lowest_class != 5'h00)) begin
                  vcc_class       <= lowest_class;
                  vcc_on          <= 1'b1;
                  activate_req    <= 1'b1;
                  first_class_reg <= 1'b1;
                  corrupt_cnt_reg <= 2'h0;
                  rejected        <= 1'b0;
                  class_bad_adv   <= 1'b0;
                  state_reg       <= ST_ACT;
               end else if (start) begin
                  rejected <= 1'b1;
               end
            end
            ST_ACT: begin
               if (act_done) begin
                  rst_assert_n <= 1'b1;
                  state_reg    <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               // no command leaves this state until the class question is settled
               if (atr_none) begin
                  // a missing answer breaks the run of corrupted ones
                  corrupt_cnt_reg <= 2'h0;
                  if (next_higher != 5'h00) begin
                     next_class_reg <= next_higher;
                     state_reg      <= ST_DEACT;
                  end else begin
                     state_reg <= ST_REJ;
                  end
                  timer_reg    <= DEACT_CYC;
                  vcc_on       <= 1'b0;
                  rst_assert_n <= 1'b0;
               end else if (atr_corrupt) begin
                  rst_assert_n <= 1'b0;
                  if (corrupt_cnt_reg != `SCS_CORRUPT_MAX - 2'h1) begin
                     corrupt_cnt_reg <= corrupt_cnt_reg + 2'h1;
                     activate_req    <= 1'b1;
                     state_reg       <= ST_ACT;
                  end else if (!corrupt_retry_reg && (next_higher != 5'h00)) begin
                     corrupt_retry_reg <= 1'b1;
                     corrupt_cnt_reg   <= 2'h0;
                     next_class_reg    <= next_higher;
                     vcc_on            <= 1'b0;
                     timer_reg         <= DEACT_CYC;
                     state_reg         <= ST_DEACT;
                  end else begin
                     state_reg <= ST_REJ;
                  end
               end else if (atr_ok) begin
                  corrupt_cnt_reg <= 2'h0;
                  class_bad_adv   <= atr_classes_present && !adjacent_ok;
                  if (!atr_classes_present || cur_ok) begin
                     apdu_allowed <= 1'b1;
                     state_reg    <= ST_READY;
                  end else if ((pick_class != 5'h00) && first_class_reg) begin
                     next_class_reg <= pick_class;
                     vcc_on         <= 1'b0;
                     rst_assert_n   <= 1'b0;
                     timer_reg      <= DEACT_CYC;
                     state_reg      <= ST_DEACT;
                  end else begin
                     // deactivation is optional; dropping supply is the safe choice
                     vcc_on       <= 1'b0;
                     rst_assert_n <= 1'b0;
                     state_reg    <= ST_REJ;
                  end
               end
            end
            ST_DEACT: begin
               if (timer_reg <= 9'h001) begin
                  vcc_class       <= next_class_reg;
                  vcc_on          <= 1'b1;
                  activate_req    <= 1'b1;
                  first_class_reg <= 1'b0;
                  state_reg       <= ST_ACT;
               end else begin
                  timer_reg <= timer_reg - 9'h001;
               end
            end
            ST_READY: begin
               if (power_down) begin
                  vcc_on            <= 1'b0;
                  rst_assert_n      <= 1'b0;
                  apdu_allowed      <= 1'b0;
                  corrupt_retry_reg <= 1'b0;
                  state_reg         <= ST_IDLE;
               end
            end
            ST_REJ: begin
               rejected     <= 1'b1;
               apdu_allowed <= 1'b0;
               vcc_on       <= 1'b0;
               rst_assert_n <= 1'b0;
               if (power_down) begin
                  corrupt_retry_reg <= 1'b0;
                  state_reg         <= ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // current allowance: capability and USB grants sticky until power-down; application grant follows the last selection event
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cap_granted_reg <= 1'b0;
         app_sel_reg     <= 1'b0;
         current_allow   <= `SCS_ALLOW_DEFAULT;
         deselect_req    <= 1'b0;
      end else begin
         deselect_req <= 1'b0;
         if (power_down) begin
            cap_granted_reg <= 1'b0;
            app_sel_reg     <= 1'b0;
            current_allow   <= `SCS_ALLOW_DEFAULT;
         end else begin
            if (cap_cmd_higher) begin
               cap_granted_reg <= 1'b1;
            end
            // one deselect pulse for every cycle the selection condition is high with power over; there is no edge detection
            if (app_access_ok || (app_no_access_cond && app_cmd_done)) begin
               app_sel_reg  <= app_power_valid && !app_power_over;
               deselect_req <= app_power_valid && app_power_over;
            end
            if (usb_activate || (current_allow == `SCS_ALLOW_USB)) begin
               current_allow <= `SCS_ALLOW_USB;
            end else if (app_sel_reg) begin
               current_allow <= `SCS_ALLOW_APP;
            end else if (cap_granted_reg) begin
               current_allow <= `SCS_ALLOW_ANNOUNCE;
            end else begin
               current_allow <= `SCS_ALLOW_DEFAULT;
            end
         end
      end
   end
endmodule // scs_sequencer
`default_nettype wire

// ==== rtl/scs_defines.vh ====
// constants of the supply class selection sequencer (terminal side)
// assumes a 20 MHz clock; no registers reachable by software
// What this block does
// - first activation uses the lowest supply class the terminal supports.
// - no answer-to-reset: deactivate, reactivate at the adjacent higher class if supported, else reject.
// - answer at first class is parsed before any further card action.
// - current class not advertised but another supported: reactivate at advertised class from the first class only, else reject.
// - no advertised class supported: never issue commands; deactivation optional.
// - corrupted answer: reset at least 3 times at same class before rejecting.
// - after 3 corrupted answers a retry may only use the next higher class.
// - after a higher-power capability command, honour that draw until power-down.
// - application counts selected after access check, or after an application command when it has no access condition.
// - deselect an application needing more power than announced.
// - activating inter-chip USB raises the granted current allowance.
// - application without power figure gets default or announced limit.
// - class switching completes before any unrelated activity starts.
`ifndef SCS_DEFINES_VH
`define SCS_DEFINES_VH
`define SCS_CLASS_W        5
`define SCS_CLASS_A        5'h01
`define SCS_CLASS_E        5'h10
`define SCS_CORRUPT_MAX    2'h3
`define SCS_CLK_HZ         20000000
`define SCS_DEACT_US       10
`define SCS_DEACT_CYC      ((`SCS_DEACT_US * `SCS_CLK_HZ + 999999) / 1000000)
`define SCS_ALLOW_DEFAULT  2'h0
`define SCS_ALLOW_ANNOUNCE 2'h1
`define SCS_ALLOW_APP      2'h2
`define SCS_ALLOW_USB      2'h3
`endif

// ==== rtl/scs_class_eval.v ====
// combinational evaluation of the advertised class byte against terminal support
// assumes class field in the low five bits of the global interface byte
`timescale 1ns/10ps
`default_nettype none
`include "scs_defines.vh"
module scs_class_eval (
   input  wire [4:0] adv_classes,
   input  wire [4:0] term_classes,
   input  wire [4:0] cur_class,
   output reg        cur_ok,
   output reg        adjacent_ok,
   output reg  [4:0] pick_class
);
   reg       seen_gap;
   reg       seen_one;
   integer   i;
   always @* begin
      seen_gap    = 1'b0;
      seen_one    = 1'b0;
      adjacent_ok = 1'b1;
      pick_class  = 5'h00;
      cur_ok      = |(adv_classes & cur_class);
      for (i = 0; i < 5; i = i + 1) begin
         if (adv_classes[i]) begin
            if (seen_gap) begin
               adjacent_ok = 1'b0;
            end
            seen_one = 1'b1;
         end else if (seen_one) begin
            seen_gap = 1'b1;
         end
      end
      // highest common bit wins, to keep the card at the lowest voltage
      for (i = 0; i < 5; i = i + 1) begin
         if (adv_classes[i] && term_classes[i]) begin
            pick_class = 5'h01 << i;
         end
      end
   end
endmodule // scs_class_eval
`default_nettype wire

// ==== dv/scs_seq_props.sv ====
// assertions on the sequencer ports: class choice, switching, rejection
// assumes one clock domain; bound onto every scs_sequencer instance
`timescale 1ns/10ps
`default_nettype none
module scs_seq_props (
   input wire logic       clock,
   input wire logic       arst_n,
   input wire logic [4:0] term_classes,
   input wire logic       start,
   input wire logic       atr_none,
   input wire logic       atr_ok,
   input wire logic       atr_corrupt,
   input wire logic [4:0] atr_classes,
   input wire logic       atr_classes_present,
   input wire logic       vcc_on,
   input wire logic [4:0] vcc_class,
   input wire logic       rst_assert_n,
   input wire logic       activate_req,
   input wire logic       apdu_allowed,
   input wire logic       rejected,
   input wire logic       class_bad_adv
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   logic [4:0] want_reg;
   logic [1:0] corr_reg;
   logic       nxt_ok, r4_ev, sw_ev, adv_ok, first_reg, retry_reg;
   // one-hot of the highest set bit, i.e. lowest voltage
   function automatic logic [4:0] low_v(input logic [4:0] x);
      low_v = 5'h00;
      for (int i = 0; i < 5; i++)
         if (x[i]) low_v = 5'h01 << i;
   endfunction
   //////////////////////////////
   assign adv_ok = ((({1'b0, atr_classes} - 6'h01) | atr_classes) + 6'h01 & atr_classes) == 6'h00;
   assign nxt_ok = (term_classes & (vcc_class >> 1)) != 5'h00;
   // class change on the advertised set only from the first applied class
   assign r4_ev = first_reg && atr_ok && atr_classes_present && (atr_classes & vcc_class) == 5'h00
                  && (atr_classes & term_classes) != 5'h00;
   assign sw_ev = r4_ev
                  || ((atr_none || (atr_corrupt && corr_reg == 2'h2 && !retry_reg)) && nxt_ok);
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         want_reg  <= 5'h00;
         corr_reg  <= 2'h0;
         first_reg <= 1'b0;
         retry_reg <= 1'b0;
      end else begin
         if (r4_ev) want_reg <= atr_classes & term_classes;
         else if (sw_ev) want_reg <= vcc_class >> 1;
         else if (activate_req) want_reg <= 5'h00;
         if (start || atr_ok || atr_none || (atr_corrupt && corr_reg == 2'h2)) corr_reg <= 2'h0;
         else if (atr_corrupt) corr_reg <= corr_reg + 2'h1;
         if (start) first_reg <= 1'b1;
         else if (sw_ev) first_reg <= 1'b0;
         if (start) retry_reg <= 1'b0;
         else if (atr_corrupt && corr_reg == 2'h2 && nxt_ok) retry_reg <= 1'b1;
      end
   end
   sequence s_off_gap;
      !vcc_on [*8] ##[185:200] (vcc_on && activate_req);
   endsequence
   AST_FIRST_LOWEST: assert property (
      start && !vcc_on && !rejected && term_classes != 5'h00
      |=> vcc_on && activate_req && vcc_class == low_v(term_classes)) else $error("first class");
   AST_SWITCH_GAP: assert property (sw_ev |=> s_off_gap) else $error("switch gap");
   AST_SWITCH_CLASS: assert property (
      activate_req && want_reg != 5'h00 |-> vcc_on && (vcc_class & want_reg) != 5'h00)
      else $error("switch class");
   AST_ATR_OK: assert property (
      atr_ok && atr_classes_present && adv_ok && (atr_classes & vcc_class) != 5'h00
      |=> apdu_allowed) else $error("answer not used");
   AST_NO_COMMON: assert property (
      atr_ok && atr_classes_present && (atr_classes & term_classes) == 5'h00
      |=> ##1 rejected && !apdu_allowed && !vcc_on) else $error("no common class");
   AST_CORRUPT_HOLD: assert property (
      atr_corrupt && corr_reg < 2'h2 |=> vcc_on && $stable(vcc_class) && !rejected)
      else $error("corrupt retry");
   AST_EXHAUST: assert property (
      (atr_none || (atr_corrupt && corr_reg == 2'h2)) && !nxt_ok |=> ##1 rejected && !apdu_allowed)
      else $error("not rejected");
   AST_BAD_ADV: assert property (
      atr_ok && atr_classes_present && !adv_ok |=> class_bad_adv) else $error("gap missed");
   AST_SETTLED: assert property (
      apdu_allowed |-> vcc_on && rst_assert_n && !rejected) else $error("early commands");
endmodule // scs_seq_props
bind scs_sequencer scs_seq_props scs_seq_props_inst (.*);
`default_nettype wire

// ==== dv/scs_card_model.sv ====
// card and contact engine model: activation, answer with class byte
// assumes the sequencer drives activate_req and the card reset line
`timescale 1ns/10ps
`default_nettype none
module scs_card_model (
   input  wire logic       clock,
   input  wire logic       arst_n,
   input  wire logic       activate_req,
   input  wire logic       rst_assert_n,
   input  wire logic [4:0] vcc_class,
   input  wire logic [4:0] adv,
   input  wire logic [4:0] mute,
   input  wire logic [4:0] cmask,
   output var  logic       act_done,
   output var  logic       atr_none,
   output var  logic       atr_ok,
   output var  logic       atr_corrupt,
   output var  logic [4:0] atr_classes,
   output var  logic       atr_classes_present
);
   logic [3:0] step_reg;
   //////////////////////////////
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         step_reg <= 4'h0;
         {act_done, atr_none, atr_ok, atr_corrupt} <= 4'h0;
         atr_classes <= 5'h00;
         atr_classes_present <= 1'b0;
      end else begin
         {act_done, atr_none, atr_ok, atr_corrupt} <= 4'h0;
         // stale class byte is inverted so it never looks valid
         atr_classes <= ~adv;
         atr_classes_present <= 1'b0;
         if (activate_req) step_reg <= 4'h1;
         else if (step_reg != 4'h0) step_reg <= step_reg + 4'h1;
         if (step_reg == 4'h4) act_done <= 1'b1;
         if (step_reg == 4'hC) begin
            step_reg <= 4'h0;
            if ((vcc_class & mute) != 5'h00 || !rst_assert_n) atr_none <= 1'b1;
            else if ((vcc_class & cmask) != 5'h00) atr_corrupt <= 1'b1;
            else begin
               atr_ok <= 1'b1;
               atr_classes <= adv;
               atr_classes_present <= adv != 5'h00;
            end
         end
      end
   end
endmodule // scs_card_model
`default_nettype wire

// ==== dv/tb.sv ====
// self-checking bench for the supply class sequencer with a card model
// assumes the sequencer, its checker and the card model are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic clock, arst_n, start, act_done, atr_none, atr_ok, atr_corrupt, atr_classes_present;
   logic cap_cmd_higher, app_access_ok, app_cmd_done, app_no_access_cond, app_power_valid;
   logic app_power_over, usb_activate, power_down, vcc_on, rst_assert_n, activate_req;
   logic apdu_allowed, rejected, deselect_req, class_bad_adv;
   logic [4:0] term_classes, atr_classes, vcc_class, adv, mute, cmask;
   logic [1:0] current_allow;
   int err_total = 0, tests_run = 0, n_corr = 0, n_desel = 0;
   wire [4:0] flags = {vcc_on, apdu_allowed, rejected, current_allow};
   scs_sequencer scs_sequencer_inst (.*);
   scs_card_model scs_card_model_inst (.*);
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   always @(posedge clock) begin
      if (atr_corrupt === 1'b1) n_corr++;
      if (deselect_req === 1'b1) n_desel++;
   end
   //////////////////////////////
   task automatic check(input string what, input logic [4:0] seen, input logic [4:0] want);
      tests_run++;
      if (seen !== want) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // app command, usb, capability, access, power-down pulses; grants settle in two edges
   task automatic hit(input logic [4:0] w);
      {app_cmd_done, usb_activate, cap_cmd_higher, app_access_ok, power_down} <= w;
      @(posedge clock);
      {app_cmd_done, usb_activate, cap_cmd_higher, app_access_ok, power_down} <= 5'h00;
      repeat (2) @(posedge clock);
   endtask
   task automatic session(input logic [4:0] t, a, m, c);
      int k;
      arst_n <= 1'b0;
      term_classes <= t;
      adv <= a;
      mute <= m;
      cmask <= c;
      repeat (12) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      n_corr = 0;
      start <= 1'b1;
      @(posedge clock);
      start <= 1'b0;
      for (k = 0; k < 3000 && apdu_allowed !== 1'b1 && rejected !== 1'b1; k++)
         @(posedge clock);
   endtask
   //////////////////////////////
   task automatic t_grants;
      session(5'h07, 5'h06, 5'h00, 5'h00);
      check("class", vcc_class, 5'h04);
      check("flags", flags, 5'h18);
      hit(5'h04);
      hit(5'h02);
      check("flags", flags, 5'h19);
      app_power_valid <= 1'b1;
      hit(5'h02);
      check("flags", flags, 5'h1A);
      hit(5'h08);
      check("flags", flags, 5'h1B);
      hit(5'h01);
      check("flags", flags, 5'h00);
      app_power_valid <= 1'b0;
   endtask
   task automatic t_desel;
      session(5'h07, 5'h06, 5'h00, 5'h00);
      n_desel = 0;
      app_power_valid <= 1'b1;
      app_power_over <= 1'b1;
      hit(5'h02);
      @(posedge clock);
      check("deselect", n_desel[4:0], 5'h01);
      check("flags", flags, 5'h18);
      app_power_over <= 1'b0;
      hit(5'h10);
      check("flags", flags, 5'h18);
      app_no_access_cond <= 1'b1;
      hit(5'h10);
      check("flags", flags, 5'h1A);
      check("deselect", n_desel[4:0], 5'h01);
      app_power_valid <= 1'b0;
      app_no_access_cond <= 1'b0;
   endtask
   task automatic t_switch;
      session(5'h07, 5'h06, 5'h04, 5'h00);
      check("class", vcc_class, 5'h02);
      check("flags", flags, 5'h18);
      session(5'h07, 5'h01, 5'h00, 5'h00);
      check("class", vcc_class, 5'h01);
      check("flags", flags, 5'h18);
      session(5'h06, 5'h01, 5'h00, 5'h00);
      check("flags", flags, 5'h04);
   endtask
   task automatic t_corrupt;
      session(5'h06, 5'h06, 5'h00, 5'h04);
      check("corrupts", n_corr[4:0], 5'h03);
      check("class", vcc_class, 5'h02);
      check("flags", flags, 5'h18);
      session(5'h04, 5'h04, 5'h00, 5'h04);
      check("corrupts", n_corr[4:0], 5'h03);
      check("reject", {3'h0, apdu_allowed, rejected}, 5'h01);
   endtask
   task automatic t_bad_adv;
      session(5'h01, 5'h05, 5'h00, 5'h00);
      check("bad_adv", {4'h0, class_bad_adv}, 5'h01);
   endtask
   initial begin
      {arst_n, start, cap_cmd_higher, app_access_ok, app_cmd_done} = 5'h00;
      {app_no_access_cond, app_power_valid, app_power_over, usb_activate, power_down} = 5'h00;
      {term_classes, adv, mute, cmask} = 20'h00000;
      t_grants;
      t_desel;
      t_switch;
      t_corrupt;
      t_bad_adv;
      results;
   end
   initial begin
      #(60000 * 50);
      err_total++;
      results;
   end
endmodule // tb
`default_nettype wire
